// ### rtl/mps_defs.svh
// Constants for the multilane receive lane acquisition and client stream.
// Assumes nothing but being included by name once per compilation unit.
`ifndef MPS_DEFS_SVH
`define MPS_DEFS_SVH

// ----------------------------------------------------------------
// Lane geometry
// ----------------------------------------------------------------
`define MPS_VL_40G        5'd4
`define MPS_VL_100G       5'd20
`define MPS_MAX_VL        20
`define MPS_PL_MAX        10
`define MPS_WORD_W        66
`define MPS_HDR_DATA      2'b01
`define MPS_HDR_CTRL      2'b10

// ----------------------------------------------------------------
// Hysteresis counts
// ----------------------------------------------------------------
`define MPS_SH_LOCK_CNT   7'd64
`define MPS_SH_BAD_MAX    5'd16
`define MPS_AM_LOCK_CNT   3'd4
`define MPS_AM_BAD_MAX    3'd4
`define MPS_AM_PERIOD     14'd16383

// ----------------------------------------------------------------
// Client stream
// ----------------------------------------------------------------
`define MPS_DATA_W        256
`define MPS_EMPTY_W       5

`endif

// ### rtl/mps_lane_lock.sv
// Word boundary and lane tag lock for one serial 66-bit lane stream.
// Assumes one 66-bit candidate word per clock; slip shifts one bit.
`timescale 1ns/1ps
`include "mps_defs.svh"

module mps_lane_lock
(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [65:0]       word_i,
  input  wire logic              tag_seen_i,
  input  wire logic [4:0]        tag_id_i,
  input  wire logic              restart_i,
  output logic                   slip_o,
  output logic                   word_lock_o,
  output logic                   tag_lock_o,
  output logic [4:0]             lane_id_o
);
  import mps_pkg::*;

  mps_sh_state_t sh_r;
  logic [6:0]    good_r;
  logic [4:0]    bad_r;
  logic [2:0]    am_good_r;
  logic [2:0]    am_bad_r;
  logic [13:0]   am_cnt_r;
  logic          hdr_ok;

  function automatic logic hdr_valid(input logic [1:0] h);
    hdr_valid = (h == `MPS_HDR_DATA) || (h == `MPS_HDR_CTRL);
  endfunction

  assign hdr_ok = hdr_valid(word_i[65:64]);

  // ----------------------------------------------------------------
  // Word lock: one candidate offset tested at a time
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || restart_i)
    begin
      sh_r   <= SH_HUNT;
      good_r <= 7'h00;
      bad_r  <= 5'h00;
      slip_o <= 1'b0;
    end
    else
    begin
      slip_o <= 1'b0;
      case (sh_r)
        SH_HUNT:
        begin
          good_r <= 7'h00;
          bad_r  <= 5'h00;
          sh_r   <= SH_TEST;
        end
        SH_TEST:
        begin
          if (!hdr_ok)
          begin
            slip_o <= 1'b1;
            sh_r   <= SH_HUNT;
          end
          else if (good_r == `MPS_SH_LOCK_CNT - 7'd1)
            sh_r <= SH_LOCK;
          else
            good_r <= good_r + 7'd1;
        end
        SH_LOCK:
        begin
          good_r <= good_r + 7'd1;
          if (!hdr_ok)
            bad_r <= bad_r + 5'd1;
          if (!hdr_ok && bad_r == `MPS_SH_BAD_MAX - 5'd1)
          begin
            slip_o <= 1'b1;
            sh_r   <= SH_HUNT;
          end
          else if (good_r == `MPS_SH_LOCK_CNT - 7'd1)
          begin
            good_r <= 7'h00;
            bad_r  <= 5'h00;
          end
        end
        default: sh_r <= SH_HUNT;
      endcase
    end
  end

  assign word_lock_o = (sh_r == SH_LOCK);

  // ----------------------------------------------------------------
  // Lane tag lock with hysteresis
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || restart_i || !word_lock_o)
    begin
      am_good_r  <= 3'h0;
      am_bad_r   <= 3'h0;
      am_cnt_r   <= 14'h0000;
      tag_lock_o <= 1'b0;
      lane_id_o  <= 5'h00;
    end
    else if (am_good_r == 3'h0)
    begin
      if (tag_seen_i)
      begin
        lane_id_o <= tag_id_i;
        am_good_r <= 3'h1;
        am_cnt_r  <= 14'h0000;
      end
    end
    else
    begin
      am_cnt_r <= am_cnt_r + 14'h0001;
      if (am_cnt_r == `MPS_AM_PERIOD)
      begin
        am_cnt_r <= 14'h0000;
        if (tag_seen_i && tag_id_i == lane_id_o)
        begin
          am_bad_r <= 3'h0;
          if (am_good_r != `MPS_AM_LOCK_CNT)
            am_good_r <= am_good_r + 3'h1;
          if (am_good_r == `MPS_AM_LOCK_CNT - 3'h1)
            tag_lock_o <= 1'b1;
        end
        else if (!tag_lock_o || am_bad_r == `MPS_AM_BAD_MAX - 3'h1)
        begin
          am_good_r  <= 3'h0;
          am_bad_r   <= 3'h0;
          tag_lock_o <= 1'b0;
        end
        else
          am_bad_r <= am_bad_r + 3'h1;
      end
    end
  end

endmodule

// ### rtl/mps_pkg.sv
// Types shared by the lane acquisition and client stream files.
// Assumes mps_defs.svh is reachable on the include path.
`include "mps_defs.svh"

package mps_pkg;

  typedef struct packed
  {
    logic [255:0] data;
    logic         first;
    logic         last;
    logic [4:0]   unused;
    logic         err;
  } mps_beat_t;

  typedef enum logic [1:0]
  {
    SH_HUNT,
    SH_TEST,
    SH_LOCK
  } mps_sh_state_t;

  typedef enum logic [1:0]
  {
    AL_WAIT_LOCK,
    AL_DESKEW,
    AL_READY
  } mps_align_state_t;

endpackage

// ### rtl/mps_skid.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes source and sink share the clock; no word lost on a stall.
`timescale 1ns/1ps

module mps_skid
(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire mps_pkg::mps_beat_t in_i,
  input  wire logic              in_valid_i,
  output logic                   in_ready_o,
  output mps_pkg::mps_beat_t     out_o,
  output logic                   out_valid_o,
  input  wire logic              out_ready_i
);
  import mps_pkg::*;

  mps_beat_t mem_r [2];
  logic      wp_r;
  logic      rp_r;
  logic [1:0] cnt_r;
  logic      push;
  logic      pop;

  assign in_ready_o  = (cnt_r != 2'd2);
  assign out_valid_o = (cnt_r != 2'd0);
  assign out_o       = mem_r[rp_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_r[wp_r] <= in_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'd0;
    end
    else
    begin
      if (push)
        wp_r <= ~wp_r;
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// ### rtl/mps_stream.sv
// Receive lane acquisition and client packet stream, top level.
// Assumes lanes arrive word-aligned per clock candidate, one clock.
//
// How it works
// - Last beat carries 5-bit count of unused low-order bytes, both ways.
// - Receive side marks first and last beat of every packet.
// - Receive data holds its value whenever receive valid is low.
// - Transmit beat accepted in the same cycle that ready is shown.
// - Forty gigabit mode uses exactly four lanes, one per physical lane.
// - Hundred gigabit mode uses twenty lanes over ten physical lanes.
// - Periodic lane tag per lane gives original lane number on LANE_ORDER_O.
// - Each 66-bit word starts with header 01 or 10, never 00 or 11.
// - Word boundary found by searching for valid header positions.
// - Candidate alignments tested one at a time, never in parallel.
// - Word and tag lock need repeated success to gain, failures to lose.
// - Per physical lane flag shows word and lane tag both locked.
// - After a severe error acquisition restarts without outside command.
// - Receive stream errors are detected and reported to the client.
`timescale 1ns/1ps
`include "mps_defs.svh"

module mps_stream
(
  input  wire logic                   CLK_I,
  input  wire logic                   RST_B_I,
  input  wire logic                   MODE_100G_I,
  input  wire logic [`MPS_MAX_VL*66-1:0] LANE_WORD_I,
  input  wire logic [`MPS_MAX_VL-1:0] LANE_TAG_SEEN_I,
  input  wire logic [`MPS_MAX_VL*5-1:0] LANE_TAG_ID_I,
  input  wire logic                   LANE_FATAL_I,
  input  wire logic                   DESKEW_DONE_I,
  output logic [`MPS_MAX_VL-1:0]      LANE_SLIP_O,
  output logic [`MPS_PL_MAX-1:0]      PHY_LANE_LOCKED_O,
  output logic [`MPS_MAX_VL*5-1:0]    LANE_ORDER_O,
  output logic                        DESKEW_START_O,
  output logic                        RX_READY_O,
  input  wire mps_pkg::mps_beat_t     RX_BEAT_I,
  input  wire logic                   RX_BEAT_VALID_I,
  output logic                        RX_BEAT_READY_O,
  output logic                        CLIENT_RX_WORD_VALID_O,
  output logic [`MPS_DATA_W-1:0]      CLIENT_RX_WORD_O,
  output logic                        CLIENT_RX_FIRST_BEAT_O,
  output logic                        CLIENT_RX_LAST_BEAT_O,
  output logic [`MPS_EMPTY_W-1:0]     CLIENT_RX_UNUSED_BYTES_O,
  output logic                        CLIENT_RX_ERROR_O,
  input  wire logic                   CLIENT_RX_READY_I,
  input  wire logic                   CLIENT_TX_WORD_VALID_I,
  input  wire logic [`MPS_DATA_W-1:0] CLIENT_TX_WORD_I,
  input  wire logic                   CLIENT_TX_FIRST_BEAT_I,
  input  wire logic                   CLIENT_TX_LAST_BEAT_I,
  input  wire logic [`MPS_EMPTY_W-1:0] CLIENT_TX_UNUSED_BYTES_I,
  input  wire logic                   TX_SINK_READY_I,
  output logic                        CLIENT_TX_READY_O,
  output logic                        TX_BEAT_VALID_O,
  output mps_pkg::mps_beat_t          TX_BEAT_O,
  output logic                        TX_FRAMING_ERR_O
);
  import mps_pkg::*;

  mps_align_state_t  al_r;
  logic [`MPS_MAX_VL-1:0] slip;
  logic [`MPS_MAX_VL-1:0] wlock;
  logic [`MPS_MAX_VL-1:0] tlock;
  logic [`MPS_MAX_VL-1:0] lane_en;
  logic [`MPS_MAX_VL*5-1:0] ids;
  logic              restart_r;
  logic              all_locked;
  logic              lost_lock;
  logic              in_pkt_r;
  logic              rx_in_pkt_r;
  mps_beat_t         buf_out;
  logic              buf_valid;
  logic              buf_ready;
  logic              take;
  logic              tx_take;

  // ----------------------------------------------------------------
  // Lane set per speed
  // ----------------------------------------------------------------
  function automatic logic [`MPS_MAX_VL-1:0] lanes_used(input logic m100);
    lanes_used = m100 ? {`MPS_MAX_VL{1'b1}}
                      : {{(`MPS_MAX_VL-4){1'b0}}, 4'hF};
  endfunction

  assign lane_en = lanes_used(MODE_100G_I);

  // ----------------------------------------------------------------
  // Per virtual lane lock
  // ----------------------------------------------------------------
  for (genvar g = 0; g < `MPS_MAX_VL; g++)
  begin : g_lane
    mps_lane_lock u_lock
    (
      .clk_i      (CLK_I),
      .rst_b_i    (RST_B_I),
      .word_i     (LANE_WORD_I[g*66 +: 66]),
      .tag_seen_i (LANE_TAG_SEEN_I[g]),
      .tag_id_i   (LANE_TAG_ID_I[g*5 +: 5]),
      .restart_i  (restart_r),
      .slip_o     (slip[g]),
      .word_lock_o(wlock[g]),
      .tag_lock_o (tlock[g]),
      .lane_id_o  (ids[g*5 +: 5])
    );
  end

  assign all_locked = &(tlock | ~lane_en);
  assign lost_lock  = !all_locked;

  // ----------------------------------------------------------------
  // Lane status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      LANE_SLIP_O       <= '0;
      PHY_LANE_LOCKED_O <= '0;
      LANE_ORDER_O      <= '0;
    end
    else
    begin
      LANE_SLIP_O  <= slip & lane_en;
      LANE_ORDER_O <= ids;
      for (int p = 0; p < `MPS_PL_MAX; p++)
      begin
        if (MODE_100G_I)
          PHY_LANE_LOCKED_O[p] <= wlock[2*p] & tlock[2*p]
                                & wlock[2*p+1] & tlock[2*p+1];
        else if (p < 4)
          PHY_LANE_LOCKED_O[p] <= wlock[p] & tlock[p];
        else
          PHY_LANE_LOCKED_O[p] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alignment, deskew and self restart
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      al_r           <= AL_WAIT_LOCK;
      restart_r      <= 1'b0;
      DESKEW_START_O <= 1'b0;
      RX_READY_O     <= 1'b0;
    end
    else
    begin
      restart_r      <= 1'b0;
      DESKEW_START_O <= 1'b0;
      if (LANE_FATAL_I)
      begin
        restart_r  <= 1'b1;
        al_r       <= AL_WAIT_LOCK;
        RX_READY_O <= 1'b0;
      end
      else
      begin
        case (al_r)
          AL_WAIT_LOCK:
            if (all_locked)
            begin
              DESKEW_START_O <= 1'b1;
              al_r           <= AL_DESKEW;
            end
          AL_DESKEW:
            if (lost_lock)
              al_r <= AL_WAIT_LOCK;
            else if (DESKEW_DONE_I)
            begin
              RX_READY_O <= 1'b1;
              al_r       <= AL_READY;
            end
          AL_READY:
            if (lost_lock)
            begin
              RX_READY_O <= 1'b0;
              al_r       <= AL_WAIT_LOCK;
            end
          default: al_r <= AL_WAIT_LOCK;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive path: buffer then client register
  // ----------------------------------------------------------------
  mps_skid u_rx_buf
  (
    .clk_i      (CLK_I),
    .rst_b_i    (RST_B_I),
    .in_i       (RX_BEAT_I),
    .in_valid_i (RX_BEAT_VALID_I),
    .in_ready_o (RX_BEAT_READY_O),
    .out_o      (buf_out),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_ready)
  );

  assign buf_ready = CLIENT_RX_READY_I || !CLIENT_RX_WORD_VALID_O;
  assign take      = buf_valid && buf_ready;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      CLIENT_RX_WORD_VALID_O   <= 1'b0;
      CLIENT_RX_WORD_O         <= '0;
      CLIENT_RX_FIRST_BEAT_O   <= 1'b0;
      CLIENT_RX_LAST_BEAT_O    <= 1'b0;
      CLIENT_RX_UNUSED_BYTES_O <= '0;
      CLIENT_RX_ERROR_O        <= 1'b0;
      rx_in_pkt_r              <= 1'b0;
    end
    else if (take)
    begin
      CLIENT_RX_WORD_VALID_O   <= 1'b1;
      CLIENT_RX_WORD_O         <= buf_out.data;
      CLIENT_RX_FIRST_BEAT_O   <= buf_out.first;
      CLIENT_RX_LAST_BEAT_O    <= buf_out.last;
      CLIENT_RX_UNUSED_BYTES_O <= buf_out.last ? buf_out.unused
                                               : 5'h00;
      // Coding errors, lost lock or broken framing poison the beat
      CLIENT_RX_ERROR_O <= buf_out.err || !RX_READY_O
                         || (buf_out.first == rx_in_pkt_r);
      rx_in_pkt_r <= (rx_in_pkt_r || buf_out.first) && !buf_out.last;
    end
    else if (CLIENT_RX_READY_I)
      CLIENT_RX_WORD_VALID_O <= 1'b0;  // Data held
  end

  // ----------------------------------------------------------------
  // Transmit path, zero ready latency
  // ----------------------------------------------------------------
  assign tx_take = CLIENT_TX_WORD_VALID_I && CLIENT_TX_READY_O;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      CLIENT_TX_READY_O <= 1'b0;
      TX_BEAT_VALID_O   <= 1'b0;
      TX_BEAT_O         <= '0;
      TX_FRAMING_ERR_O  <= 1'b0;
      in_pkt_r          <= 1'b0;
    end
    else
    begin
      CLIENT_TX_READY_O <= TX_SINK_READY_I;
      TX_BEAT_VALID_O   <= tx_take;
      TX_FRAMING_ERR_O  <= 1'b0;
      if (tx_take)
      begin
        TX_BEAT_O.data   <= CLIENT_TX_WORD_I;
        TX_BEAT_O.first  <= CLIENT_TX_FIRST_BEAT_I;
        TX_BEAT_O.last   <= CLIENT_TX_LAST_BEAT_I;
        TX_BEAT_O.unused <= CLIENT_TX_LAST_BEAT_I
                            ? CLIENT_TX_UNUSED_BYTES_I : 5'h00;
        TX_BEAT_O.err    <= CLIENT_TX_FIRST_BEAT_I == in_pkt_r;
        TX_FRAMING_ERR_O <= CLIENT_TX_FIRST_BEAT_I == in_pkt_r;
        in_pkt_r <= (in_pkt_r || CLIENT_TX_FIRST_BEAT_I)
                    && !CLIENT_TX_LAST_BEAT_I;
      end
      else if (in_pkt_r && !CLIENT_TX_WORD_VALID_I)
        TX_FRAMING_ERR_O <= 1'b1;  // Gap inside packet
    end
  end

endmodule

// ### verif/mps_client_model.sv
// Client model: sends transmit packets and collects receive beats.
// Assumes its tasks are entered just after a rising edge of clk_i.
`timescale 1ns/1ps

module mps_client_model
(
  input  wire logic         clk_i,
  input  wire logic         tx_ready_i,
  input  wire logic         rx_valid_i,
  input  wire logic [255:0] rx_word_i,
  input  wire logic         rx_first_i,
  input  wire logic         rx_last_i,
  input  wire logic [4:0]   rx_unused_i,
  input  wire logic         rx_err_i,
  output logic              tx_valid_o,
  output logic [255:0]      tx_word_o,
  output logic              tx_first_o,
  output logic              tx_last_o,
  output logic [4:0]        tx_unused_o,
  output logic              rx_ready_o
);
  import mps_pkg::*;
  logic      stall;
  mps_beat_t rq[$];

  initial
  begin
    stall = 1'b0;
    rx_ready_o = 1'b1;
    tx_valid_o = 1'b0;
    tx_word_o = '0;
    tx_first_o = 1'b0;
    tx_last_o = 1'b0;
    tx_unused_o = 5'h0;
  end

  // Stall makes ready alternate, so the receive side sees back-pressure
  always @(posedge clk_i)
  begin
    if (rx_valid_i && rx_ready_o)
      rq.push_back(mps_beat_t'{rx_word_i, rx_first_i, rx_last_i,
                               rx_unused_i, rx_err_i});
    rx_ready_o <= #1 stall ? !rx_ready_o : 1'b1;
  end

  task automatic send(input logic [255:0] d, input logic f, input logic l,
                      input logic [4:0] u);
    logic ok;
    tx_valid_o = 1'b1;
    tx_word_o = d;
    tx_first_o = f;
    tx_last_o = l;
    tx_unused_o = l ? u : 5'h0;
    do
    begin
      @(negedge clk_i);
      ok = tx_ready_i;
      @(posedge clk_i);
    end while (!ok);
    #1;
  endtask

  task automatic idle();
    tx_valid_o = 1'b0;
    tx_word_o = ~tx_word_o;
    tx_first_o = 1'b0;
    tx_last_o = 1'b0;
    @(posedge clk_i);
    #1;
  endtask
endmodule

// ### verif/mps_stream_checker.sv
// Concurrent checks on the client stream and lane status ports.
// Assumes the single clock and synchronous active-low reset of the top.
`timescale 1ns/1ps
`include "mps_defs.svh"

module mps_stream_checker
(
  input wire logic                   CLK_I,
  input wire logic                   RST_B_I,
  input wire logic                   MODE_100G_I,
  input wire logic                   LANE_FATAL_I,
  input wire logic [`MPS_MAX_VL-1:0] LANE_SLIP_O,
  input wire logic                   RX_READY_O,
  input wire logic                   CLIENT_RX_WORD_VALID_O,
  input wire logic [`MPS_DATA_W-1:0] CLIENT_RX_WORD_O,
  input wire logic                   CLIENT_RX_LAST_BEAT_O,
  input wire logic [`MPS_EMPTY_W-1:0] CLIENT_RX_UNUSED_BYTES_O,
  input wire logic                   CLIENT_TX_WORD_VALID_I,
  input wire logic [`MPS_DATA_W-1:0] CLIENT_TX_WORD_I,
  input wire logic                   CLIENT_TX_FIRST_BEAT_I,
  input wire logic                   CLIENT_TX_LAST_BEAT_I,
  input wire logic [`MPS_EMPTY_W-1:0] CLIENT_TX_UNUSED_BYTES_I,
  input wire logic                   TX_SINK_READY_I,
  input wire logic                   CLIENT_TX_READY_O,
  input wire logic                   TX_BEAT_VALID_O,
  input wire mps_pkg::mps_beat_t     TX_BEAT_O,
  input wire logic                   TX_FRAMING_ERR_O
);
  import mps_pkg::*;
  logic tk;
  logic pkt_r;
  logic pkt_nxt;

  // ----------------------------------------------------------------
  // Transmit packet tracking
  // ----------------------------------------------------------------
  assign tk = CLIENT_TX_WORD_VALID_I && CLIENT_TX_READY_O;

  always_comb
  begin
    pkt_nxt = pkt_r;
    if (tk)
      pkt_nxt = !CLIENT_TX_LAST_BEAT_I && (pkt_r || CLIENT_TX_FIRST_BEAT_I);
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
      pkt_r <= 1'b0;
    else
      pkt_r <= pkt_nxt;
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  a_rx_word_hold: assert property (
    !CLIENT_RX_WORD_VALID_O && $past(RST_B_I) |-> $stable(CLIENT_RX_WORD_O))
    else $error("receive word changed while valid low");
  a_rx_unused_zero: assert property (
    CLIENT_RX_WORD_VALID_O && !CLIENT_RX_LAST_BEAT_O
      |-> CLIENT_RX_UNUSED_BYTES_O == 5'h0)
    else $error("unused byte count on a non-last beat");
  a_tx_accept_data: assert property (
    tk |=> TX_BEAT_VALID_O && TX_BEAT_O.data == $past(CLIENT_TX_WORD_I))
    else $error("accepted transmit word not forwarded");
  a_tx_marks_pass: assert property (
    tk |=> TX_BEAT_O.first == $past(CLIENT_TX_FIRST_BEAT_I)
      && TX_BEAT_O.last == $past(CLIENT_TX_LAST_BEAT_I)
      && TX_BEAT_O.unused == $past(CLIENT_TX_UNUSED_BYTES_I))
    else $error("transmit marks not forwarded");
  a_tx_no_take: assert property (
    !tk |=> !TX_BEAT_VALID_O)
    else $error("transmit beat without handshake");
  a_tx_ready_lag: assert property (
    $past(RST_B_I) |-> CLIENT_TX_READY_O == $past(TX_SINK_READY_I))
    else $error("transmit ready does not follow sink ready");
  a_tx_gap_flag: assert property (
    pkt_r && !CLIENT_TX_WORD_VALID_I |=> TX_FRAMING_ERR_O)
    else $error("valid gap inside packet not flagged");
  a_fatal_unready: assert property (
    LANE_FATAL_I |=> !RX_READY_O)
    else $error("ready kept after severe error");
  a_slip_lane_use: assert property (
    !MODE_100G_I |-> LANE_SLIP_O[19:4] == 16'h0)
    else $error("slip on a lane unused in forty gigabit mode");

  c_tx_last: cover property (tk && CLIENT_TX_LAST_BEAT_I);
  c_rx_last: cover property (CLIENT_RX_WORD_VALID_O && CLIENT_RX_LAST_BEAT_O);
  c_slip: cover property (LANE_SLIP_O[0]);
  c_gap: cover property (TX_FRAMING_ERR_O);
endmodule

bind mps_stream mps_stream_checker u_chk
(
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .MODE_100G_I(MODE_100G_I),
  .LANE_FATAL_I(LANE_FATAL_I), .LANE_SLIP_O(LANE_SLIP_O),
  .RX_READY_O(RX_READY_O), .CLIENT_RX_WORD_VALID_O(CLIENT_RX_WORD_VALID_O),
  .CLIENT_RX_WORD_O(CLIENT_RX_WORD_O),
  .CLIENT_RX_LAST_BEAT_O(CLIENT_RX_LAST_BEAT_O),
  .CLIENT_RX_UNUSED_BYTES_O(CLIENT_RX_UNUSED_BYTES_O),
  .CLIENT_TX_WORD_VALID_I(CLIENT_TX_WORD_VALID_I),
  .CLIENT_TX_WORD_I(CLIENT_TX_WORD_I),
  .CLIENT_TX_FIRST_BEAT_I(CLIENT_TX_FIRST_BEAT_I),
  .CLIENT_TX_LAST_BEAT_I(CLIENT_TX_LAST_BEAT_I),
  .CLIENT_TX_UNUSED_BYTES_I(CLIENT_TX_UNUSED_BYTES_I),
  .TX_SINK_READY_I(TX_SINK_READY_I), .CLIENT_TX_READY_O(CLIENT_TX_READY_O),
  .TX_BEAT_VALID_O(TX_BEAT_VALID_O), .TX_BEAT_O(TX_BEAT_O),
  .TX_FRAMING_ERR_O(TX_FRAMING_ERR_O)
);

// ### verif/mps_stream_tb.sv
// Self-checking bench: lane headers, hysteresis, restart, client streams.
// Assumes mps_client_model as client and the checker bound to the top.
`timescale 1ns/1ps
`include "mps_defs.svh"

module mps_stream_tb;
  import mps_pkg::*;
  logic          clk, rst_b, fatal, sink_rdy, rbv, rbrdy, rx_rdy, ferr_seen;
  logic          cv, cf, cl, ce, crdy, tv, tf, tl, trdy, tbv, ferr, dsk;
  logic [1319:0] lw;
  logic [99:0]   ord;
  logic [9:0]    pll;
  logic [19:0]   slip, seen;
  logic [255:0]  cw, tw;
  logic [4:0]    cu, tu;
  mps_beat_t     rb, tb, b;
  mps_beat_t     tq[$];
  int            error_cnt, samples_checked, cyc;

  mps_stream DUT
  (
    .CLK_I(clk), .RST_B_I(rst_b), .MODE_100G_I(1'b0), .LANE_WORD_I(lw),
    .LANE_TAG_SEEN_I({20{cyc[13:0] == 14'h0400}}), .LANE_TAG_ID_I(100'h443),
    .LANE_FATAL_I(fatal), .DESKEW_DONE_I(dsk), .LANE_SLIP_O(slip),
    .PHY_LANE_LOCKED_O(pll), .LANE_ORDER_O(ord), .DESKEW_START_O(dsk),
    .RX_READY_O(rx_rdy),
    .RX_BEAT_I(rb), .RX_BEAT_VALID_I(rbv), .RX_BEAT_READY_O(rbrdy),
    .CLIENT_RX_WORD_VALID_O(cv), .CLIENT_RX_WORD_O(cw),
    .CLIENT_RX_FIRST_BEAT_O(cf), .CLIENT_RX_LAST_BEAT_O(cl),
    .CLIENT_RX_UNUSED_BYTES_O(cu), .CLIENT_RX_ERROR_O(ce),
    .CLIENT_RX_READY_I(crdy), .CLIENT_TX_WORD_VALID_I(tv),
    .CLIENT_TX_WORD_I(tw), .CLIENT_TX_FIRST_BEAT_I(tf),
    .CLIENT_TX_LAST_BEAT_I(tl), .CLIENT_TX_UNUSED_BYTES_I(tu),
    .TX_SINK_READY_I(sink_rdy), .CLIENT_TX_READY_O(trdy),
    .TX_BEAT_VALID_O(tbv), .TX_BEAT_O(tb), .TX_FRAMING_ERR_O(ferr)
  );

  mps_client_model u_cli
  (
    .clk_i(clk), .tx_ready_i(trdy), .rx_valid_i(cv), .rx_word_i(cw),
    .rx_first_i(cf), .rx_last_i(cl), .rx_unused_i(cu), .rx_err_i(ce),
    .tx_valid_o(tv), .tx_word_o(tw), .tx_first_o(tf), .tx_last_o(tl),
    .tx_unused_o(tu), .rx_ready_o(crdy)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Monitors and timeout
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc <= #1 cyc + 1;
    seen <= seen | slip;
    ferr_seen <= ferr_seen | ferr;
    if (tbv)
      tq.push_back(tb);
    if (cyc == 60000)
    begin
      error_cnt++;
      test_done();
    end
  end

  task automatic check(input logic [255:0] got, input logic [255:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hdr(input int g, input logic [1:0] h);
    lw[g*66+64 +: 2] = h;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic push(input logic [255:0] d, input logic f, input logic l,
                      input logic [4:0] u);
    logic ok;
    rb = mps_beat_t'{d, f, l, u, 1'b0};
    rbv = 1'b1;
    do
    begin
      @(negedge clk);
      ok = rbrdy;
      @(posedge clk);
    end while (!ok);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    rst_b = 1'b0;
    fatal = 1'b0;
    sink_rdy = 1'b0;
    rbv = 1'b0;
    rb = '0;
    seen = '0;
    ferr_seen = 1'b0;
    cyc = 0;
    error_cnt = 0;
    samples_checked = 0;
    for (int g = 0; g < 20; g++)
      lw[g*66 +: 66] = {2'b01, 64'h0};
    wait_clk(10);
    rst_b = 1'b1;
    wait_clk(1);
    check(rx_rdy, 1'b0);
    check(rbrdy, 1'b1);
    // Bad codes slip; lane 5 is outside forty gigabit mode
    hdr(0, 2'b00);
    hdr(1, 2'b11);
    hdr(3, 2'b10);
    hdr(5, 2'b00);
    seen = '0;
    wait_clk(12);
    check(seen[5:0], 6'h03);
    for (int g = 0; g < 6; g++)
      hdr(g, 2'b01);
    $display("test headers done");
    wait_clk(80);
    seen = '0;
    hdr(2, 2'b00);
    wait_clk(1);
    hdr(2, 2'b01);
    hdr(3, 2'b11);
    wait_clk(20);
    hdr(3, 2'b01);
    wait_clk(6);
    check(seen[3:2], 2'b10);
    $display("test hysteresis done");
    fatal = 1'b1;
    wait_clk(1);
    fatal = 1'b0;
    wait_clk(3);
    check(rx_rdy, 1'b0);
    seen = '0;
    hdr(1, 2'b00);
    wait_clk(1);
    hdr(1, 2'b01);
    wait_clk(8);
    check(seen[1], 1'b1);
    $display("test restart done");
    u_cli.stall = 1'b1;
    for (int i = 0; i < 3; i++)
      push({8{32'hC0DE0000 | 32'(i)}}, i == 0, i == 2,
           (i == 2) ? 5'h1D : 5'h0);
    rbv = 1'b0;
    rb = ~rb;
    for (int k = 0; k < 40 && u_cli.rq.size() < 3; k++)
      wait_clk(1);
    check(u_cli.rq.size(), 3);
    for (int i = 0; i < 3 && i < u_cli.rq.size(); i++)
    begin
      b = u_cli.rq[i];
      check(b.data, {8{32'hC0DE0000 | 32'(i)}});
      check({b.first, b.last}, {i == 0, i == 2});
      check(b.unused, (i == 2) ? 5'h1D : 5'h0);
      check(b.err, 1'b1);
    end
    $display("test receive done");
    fork
      begin
        u_cli.send({8{32'h5A5A0001}}, 1'b1, 1'b0, 5'h0);
        u_cli.send({8{32'h5A5A0002}}, 1'b0, 1'b1, 5'h02);
        u_cli.idle();
      end
      begin
        wait_clk(3);
        sink_rdy = 1'b1;
      end
    join
    wait_clk(3);
    check(tq.size(), 2);
    if (tq.size() == 2)
    begin
      check(tq[0].data, {8{32'h5A5A0001}});
      check({tq[0].first, tq[1].last}, 2'b11);
      check(tq[1].unused, 5'h02);
    end
    check(ferr_seen, 1'b0);
    u_cli.send({8{32'h5A5A0003}}, 1'b1, 1'b0, 5'h0);
    u_cli.idle();
    u_cli.send({8{32'h5A5A0004}}, 1'b0, 1'b1, 5'h0);
    u_cli.idle();
    wait_clk(3);
    check(ferr_seen, 1'b1);
    while (!rx_rdy)
      wait_clk(1);
    check(rx_rdy, 1'b1);
    check(pll, 10'h00F);
    check(ord[19:0], 20'h00443);
    $display("test transmit and lanes done");
    test_done();
  end
endmodule
